/* File: dv/calendar_control_status_bench.sv */
// self-checking bench for the calendar control block
`timescale 1ns/10ps
`default_nettype none
module calendar_control_status_bench;
  // ==========================================
  // clock, ports and bookkeeping
  logic        i_sys_clk = 0, i_reset = 1, i_por = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, i_xtal_tick = 0, i_mains_tick = 0, i_alarm_match = 0;
  logic        i_count_inc = 0, i_sleeping = 0, o_second, o_wake_req, o_alarm_irq, o_irq;
  cal_ctrl_pkg::cal_cfg_t o_cfg;
  logic [32:0] expq[$];       // expected {pslverr, prdata} per read
  int          err_count = 0, n_checks = 0, secs = 0, r;
  logic [7:0]  cfg = 8'h00;   // bench copy of writable control bits
  logic        alarm = 0, wake = 0;

  always #12.5 i_sys_clk = ~i_sys_clk;

  cal_ctrl uut (.i_sys_clk, .i_reset, .i_por, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .i_xtal_tick, .i_mains_tick, .i_alarm_match, .i_count_inc,
    .i_sleeping, .o_cfg, .o_second, .o_wake_req, .o_alarm_irq, .o_irq);

  // ==========================================
  // comparison, monitor and report
  task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // compare each completed read with the oldest note
  always @(posedge i_sys_clk) begin
    if (psel && penable && pready && !pwrite) begin
      if (expq.size() == 0) chk("unexpected read", 33'h0, 33'h1_FFFF_FFFF);
      else chk("read data", expq.pop_front(), {pslverr, prdata});
    end
  end

  // count one-second pulses
  always @(posedge i_sys_clk) begin
    if (o_second === 1'b1) secs <= secs + 1;
  end

  // ==========================================
  // bus and stimulus tasks
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int k;
    @(posedge i_sys_clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge i_sys_clk);
    penable <= 1;
    for (k = 0; k < 20; k++) begin
      @(posedge i_sys_clk);
      if (pready === 1'b1) break;
    end
    if (k == 20) begin
      chk("pready", 33'h1, 33'h0);
      tally_and_finish();
    end
    psel <= 0; penable <= 0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    if (a == cal_ctrl_pkg::CTRL_ADDR) begin
      if (cfg[0] && !d[0]) alarm = i_alarm_match;   // lock re-evaluates the flag
      cfg = d[7:0] & 8'h79;
    end
    apb(a, 1'b1, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    expq.push_back(e);
    apb(a, 1'b0, 32'h0);
  endtask

  // read control and model its read-clear effects
  task automatic rdc();
    rd(cal_ctrl_pkg::CTRL_ADDR, 33'({alarm, cfg[6:3], 1'b0, wake, cfg[0]}));
    alarm = 0;
    wake = 0;
  endtask

  task automatic inc();
    @(posedge i_sys_clk);
    i_count_inc <= 1;
    @(posedge i_sys_clk);
    i_count_inc <= 0;
    alarm = i_alarm_match;
    @(negedge i_sys_clk);
  endtask

  task automatic rst();
    @(posedge i_sys_clk);
    i_reset <= 1;
    repeat (2) @(posedge i_sys_clk);
    i_reset <= 0;
    cfg = cfg & 8'hBE;
    alarm = 0;
  endtask

  task automatic ticks(input int n, input logic m);
    repeat (n) begin
      @(posedge i_sys_clk);
      if (m) i_mains_tick <= 1;
      else i_xtal_tick <= 1;
      @(posedge i_sys_clk);
      i_mains_tick <= 0;
      i_xtal_tick <= 0;
    end
    repeat (8) @(posedge i_sys_clk);
  endtask

  // restart the prescaler, then expect exactly one second after div edges
  task automatic sec_test(input int div, input logic m);
    int s;
    wr(cal_ctrl_pkg::CTRL_ADDR, {24'h0, cfg});
    s = secs;
    ticks(div - 1, m);
    chk("early second", 33'(s), 33'(secs));
    ticks(1, m);
    chk("second", 33'(s + 1), 33'(secs));
  endtask

  // ==========================================
  // main sequence
  initial begin
    void'($urandom(70));
    repeat (5) @(posedge i_sys_clk);
    i_reset <= 0;
    i_por <= 0;
    rdc();
    wr(cal_ctrl_pkg::CTRL_ADDR, 32'hFF);
    @(negedge i_sys_clk);
    chk("cfg", 33'(4'hD), 33'(o_cfg));
    rdc();
    rst();
    @(negedge i_sys_clk);
    chk("cfg after reset", 33'(4'hC), 33'(o_cfg));
    rdc();
    $display("end of reset test");
    wr(cal_ctrl_pkg::CTRL_ADDR, 32'h41);
    i_alarm_match <= 1;
    repeat (3) @(negedge i_sys_clk);
    chk("alarm held", 33'h0, 33'(o_alarm_irq));
    inc();
    chk("alarm irq", 33'h1, 33'(o_alarm_irq));
    rdc();
    @(negedge i_sys_clk);
    chk("irq after read", 33'h0, 33'(o_alarm_irq));
    wr(cal_ctrl_pkg::CTRL_ADDR, 32'h01);
    inc();
    chk("irq disabled", 33'h0, 33'(o_alarm_irq));
    rdc();
    wr(cal_ctrl_pkg::CTRL_ADDR, 32'h00);
    rdc();
    $display("end of alarm test");
    wr(cal_ctrl_pkg::CTRL_ADDR, 32'h01);
    i_sleeping <= 1;
    inc();
    chk("wake request", 33'h1, 33'(o_wake_req));
    // keep sleeping through the edge that latches the wake cause
    @(posedge i_sys_clk);
    i_sleeping <= 0;
    wake = 1;
    // alarm rise and wake events both stand in the status register
    rd(cal_ctrl_pkg::IRQ_STAT_ADDR, 33'h5);
    rst();
    rdc();
    rdc();
    $display("end of wake test");
    wr(cal_ctrl_pkg::IRQ_STAT_ADDR, 32'h7);
    wr(cal_ctrl_pkg::IRQ_MASK_ADDR, 32'h0);
    rd(cal_ctrl_pkg::IRQ_STAT_ADDR, 33'h0);
    wr(cal_ctrl_pkg::CTRL_ADDR, 32'h01);
    i_alarm_match <= 0;
    inc();
    @(posedge i_sys_clk);
    i_alarm_match <= 1;
    inc();
    rd(cal_ctrl_pkg::IRQ_STAT_ADDR, 33'h1);
    chk("masked irq", 33'h0, 33'(o_irq));
    wr(cal_ctrl_pkg::IRQ_MASK_ADDR, 32'h1);
    @(negedge i_sys_clk);
    chk("unmasked irq", 33'h1, 33'(o_irq));
    rd(cal_ctrl_pkg::IRQ_MASK_ADDR, 33'h1);
    wr(cal_ctrl_pkg::IRQ_STAT_ADDR, 32'h1);
    @(negedge i_sys_clk);
    chk("cleared irq", 33'h0, 33'(o_irq));
    rd(12'h010, 33'h1_0000_0000);
    $display("end of interrupt test");
    wr(cal_ctrl_pkg::CTRL_ADDR, 32'h10);
    @(negedge i_sys_clk);
    chk("osc off", 33'h0, 33'(o_cfg.osc_enable));
    r = $urandom_range(59, 1);
    ticks(r, 1'b1);
    sec_test(60, 1'b1);
    // the second pulse leaves only the tick bit set
    rd(cal_ctrl_pkg::IRQ_STAT_ADDR, 33'h2);
    wr(cal_ctrl_pkg::CTRL_ADDR, 32'h18);
    sec_test(50, 1'b1);
    wr(cal_ctrl_pkg::CTRL_ADDR, 32'h20);
    @(negedge i_sys_clk);
    chk("cfg crystal", 33'(4'hA), 33'(o_cfg));
    sec_test(32768, 1'b0);
    $display("end of prescaler test");
    tally_and_finish();
  end
endmodule
`default_nettype wire

/* File: verilog/cal_ctrl.sv */
// calendar control/status register block with APB slave and alarm interrupt
`timescale 1ns/10ps
`default_nettype none
module cal_ctrl (
  input  wire logic        i_sys_clk,      // 40 MHz system clock
  input  wire logic        i_reset,        // async reset, high
  input  wire logic        i_por,          // power-on reset, high, clears config
  input  wire logic        psel,           // apb select
  input  wire logic        penable,        // apb enable
  input  wire logic        pwrite,         // apb direction
  input  wire logic [11:0] paddr,          // apb byte address
  input  wire logic [31:0] pwdata,         // apb write data
  output logic      [31:0] prdata,         // apb read data
  output logic             pready,         // apb ready
  output logic             pslverr,        // apb error
  input  wire logic        i_xtal_tick,    // crystal oscillator output pin
  input  wire logic        i_mains_tick,   // mains frequency input pin
  input  wire logic        i_alarm_match,  // alarm compare result from count logic
  input  wire logic        i_count_inc,    // count increment strobe from count logic
  input  wire logic        i_sleeping,     // processor is in sleep mode
  output cal_ctrl_pkg::cal_cfg_t o_cfg,    // configuration to count logic
  output logic             o_second,       // one-second tick to count logic
  output logic             o_wake_req,     // sleep recovery request
  output logic             o_alarm_irq,    // alarm interrupt to processor
  output logic             o_irq           // combined masked interrupt
);
  // ==========================================================
  // bus decode
  logic       wr_acc;
  logic       rd_acc;
  logic       ctrl_wr;
  logic       ctrl_rd;
  logic       mapped;
  logic [7:0] wb;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
    return a == r;
  endfunction

  assign pready  = 1'b1;
  assign wr_acc  = psel & penable & pwrite;
  assign rd_acc  = psel & penable & ~pwrite;
  assign ctrl_wr = wr_acc & hit(paddr, cal_ctrl_pkg::CTRL_ADDR);
  assign ctrl_rd = rd_acc & hit(paddr, cal_ctrl_pkg::CTRL_ADDR);
  assign mapped  = hit(paddr, cal_ctrl_pkg::CTRL_ADDR) | hit(paddr, cal_ctrl_pkg::IRQ_STAT_ADDR)
                 | hit(paddr, cal_ctrl_pkg::IRQ_MASK_ADDR) | hit(paddr, cal_ctrl_pkg::MATCH_ADDR);
  assign pslverr = psel & penable & ~mapped;
  assign wb      = pwdata[7:0];

  // ==========================================================
  // control register fields
  logic int_en;
  logic bcd_mode;
  logic mains_src;
  logic rate_sel;
  logic unlock;
  logic alarm;
  logic wake;

  // interrupt enable and unlock are cleared by system reset
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      int_en <= 1'b0;
      unlock <= 1'b0;
    end else if (ctrl_wr) begin
      int_en <= wb[cal_ctrl_pkg::INTEN_BIT];
      unlock <= wb[cal_ctrl_pkg::UNLOCK_BIT];
    end
  end

  // configuration survives system reset; only power-on clears it
  always_ff @(posedge i_sys_clk or posedge i_por) begin
    if (i_por) begin
      bcd_mode  <= cal_ctrl_pkg::CTRL_POWERON[cal_ctrl_pkg::BCD_BIT];
      mains_src <= cal_ctrl_pkg::CTRL_POWERON[cal_ctrl_pkg::SRC_BIT];
      rate_sel  <= cal_ctrl_pkg::CTRL_POWERON[cal_ctrl_pkg::RATE_BIT];
    end else if (ctrl_wr) begin
      bcd_mode  <= wb[cal_ctrl_pkg::BCD_BIT];
      mains_src <= wb[cal_ctrl_pkg::SRC_BIT];
      rate_sel  <= wb[cal_ctrl_pkg::RATE_BIT];
    end
  end

  // lock event: unlock bit goes from one to zero by a write
  logic lock_evt;
  assign lock_evt = ctrl_wr & unlock & ~wb[cal_ctrl_pkg::UNLOCK_BIT];

  // alarm flag: sampled on lock or increment; a read clears, an update wins
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      alarm <= 1'b0;
    end else if (lock_evt | i_count_inc) begin
      alarm <= i_alarm_match;
    end else if (ctrl_rd) begin
      alarm <= 1'b0;
    end
  end

  // wake cause: set on alarm while asleep, kept across system reset
  always_ff @(posedge i_sys_clk or posedge i_por) begin
    if (i_por) begin
      wake <= 1'b0;
    end else if (o_wake_req) begin
      wake <= 1'b1;
    end else if (ctrl_rd) begin
      wake <= 1'b0;
    end
  end

  assign o_alarm_irq = alarm & int_en;
  assign o_wake_req  = alarm & i_sleeping;

  // configuration bundle to counters and comparators
  assign o_cfg.bcd_mode     = bcd_mode;
  assign o_cfg.mains_source = mains_src;
  assign o_cfg.osc_enable   = ~mains_src;
  assign o_cfg.unlock       = unlock;

  // ==========================================================
  // tick source and prescaler
  logic        xtal_rise;
  logic        mains_rise;
  logic        step;
  logic [15:0] divisor;

  cal_sync u_xtal_sync (
    .i_sys_clk (i_sys_clk),
    .i_reset   (i_reset),
    .i_async   (i_xtal_tick),
    .o_level   (),
    .o_rise    (xtal_rise)
  );

  cal_sync u_mains_sync (
    .i_sys_clk (i_sys_clk),
    .i_reset   (i_reset),
    .i_async   (i_mains_tick),
    .o_level   (),
    .o_rise    (mains_rise)
  );

  // pick source edge and divisor
  assign step    = mains_src ? mains_rise : xtal_rise;
  assign divisor = ~mains_src ? cal_ctrl_pkg::DIV_XTAL :
                   (rate_sel ? cal_ctrl_pkg::DIV_50HZ : cal_ctrl_pkg::DIV_60HZ);

  cal_prescaler u_prescaler (
    .i_sys_clk (i_sys_clk),
    .i_reset   (i_reset),
    .i_clear   (ctrl_wr),
    .i_step    (step),
    .i_divisor (divisor),
    .o_second  (o_second)
  );

  // ==========================================================
  // interrupt status and mask
  logic [cal_ctrl_pkg::EV_N-1:0] irq_stat;
  logic [cal_ctrl_pkg::EV_N-1:0] irq_mask;
  logic [cal_ctrl_pkg::EV_N-1:0] events;
  logic                          alarm_q;

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      alarm_q <= 1'b0;
    end else begin
      alarm_q <= alarm;
    end
  end

  assign events[cal_ctrl_pkg::EV_ALARM] = alarm & ~alarm_q;
  assign events[cal_ctrl_pkg::EV_TICK]  = o_second;
  assign events[cal_ctrl_pkg::EV_WAKE]  = o_wake_req;

  // sticky status; set wins over write-one-to-clear
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      irq_stat <= '0;
    end else begin
      for (int i = 0; i < cal_ctrl_pkg::EV_N; i++) begin
        if (events[i]) begin
          irq_stat[i] <= 1'b1;
        end else if (wr_acc && hit(paddr, cal_ctrl_pkg::IRQ_STAT_ADDR) && pwdata[i]) begin
          irq_stat[i] <= 1'b0;
        end
      end
    end
  end

  // mask register
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      irq_mask <= '0;
    end else if (wr_acc && hit(paddr, cal_ctrl_pkg::IRQ_MASK_ADDR)) begin
      irq_mask <= pwdata[cal_ctrl_pkg::EV_N-1:0];
    end
  end

  assign o_irq = |(irq_stat & irq_mask);

  // ==========================================================
  // read data
  logic [7:0] ctrl_view;
  always_comb begin
    ctrl_view = 8'h00;
    ctrl_view[cal_ctrl_pkg::ALARM_BIT]  = alarm;
    ctrl_view[cal_ctrl_pkg::INTEN_BIT]  = int_en;
    ctrl_view[cal_ctrl_pkg::BCD_BIT]    = bcd_mode;
    ctrl_view[cal_ctrl_pkg::SRC_BIT]    = mains_src;
    ctrl_view[cal_ctrl_pkg::RATE_BIT]   = rate_sel;
    ctrl_view[cal_ctrl_pkg::WAKE_BIT]   = wake;
    ctrl_view[cal_ctrl_pkg::UNLOCK_BIT] = unlock;
  end

  // registered read data, loaded in the setup phase
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      prdata <= 32'h00000000;
    end else if (psel & ~penable & ~pwrite) begin
      if (hit(paddr, cal_ctrl_pkg::CTRL_ADDR)) begin
        prdata <= {24'h000000, ctrl_view};
      end else if (hit(paddr, cal_ctrl_pkg::IRQ_STAT_ADDR)) begin
        prdata <= {29'h00000000, irq_stat};
      end else if (hit(paddr, cal_ctrl_pkg::IRQ_MASK_ADDR)) begin
        prdata <= {29'h00000000, irq_mask};
      end else if (hit(paddr, cal_ctrl_pkg::MATCH_ADDR)) begin
        prdata <= {31'h00000000, i_alarm_match};
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end

  // ==========================================================
  // checks
  property p_read_clears;
    @(posedge i_sys_clk) disable iff (i_reset)
    ctrl_rd && !(lock_evt || i_count_inc) |=> !alarm && !o_alarm_irq;
  endproperty
  a_read_clears: assert property (p_read_clears)
    else $error("alarm not cleared by read");

  property p_alarm_hold;
    @(posedge i_sys_clk) disable iff (i_reset)
    !(lock_evt || i_count_inc || ctrl_rd) |=> alarm == $past(alarm);
  endproperty
  a_alarm_hold: assert property (p_alarm_hold)
    else $error("alarm changed without cause");

  property p_alarm_load;
    @(posedge i_sys_clk) disable iff (i_reset)
    (lock_evt || i_count_inc) |=> alarm == $past(i_alarm_match);
  endproperty
  a_alarm_load: assert property (p_alarm_load)
    else $error("alarm not reloaded");

  property p_irq_gate;
    @(posedge i_sys_clk) disable iff (i_reset)
    o_alarm_irq == (alarm && int_en);
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("alarm irq gating wrong");

  property p_wake_set;
    @(posedge i_sys_clk) disable iff (i_reset)
    alarm && i_sleeping |=> wake;
  endproperty
  a_wake_set: assert property (p_wake_set)
    else $error("wake cause not set");

  // wake cause survives system reset, so only power-on disables this one
  property p_wake_clear;
    @(posedge i_sys_clk) disable iff (i_por)
    ctrl_rd && !o_wake_req |=> !wake;
  endproperty
  a_wake_clear: assert property (p_wake_clear)
    else $error("wake cause not cleared by read");

  property p_osc;
    @(posedge i_sys_clk) disable iff (i_reset)
    ctrl_wr |=> o_cfg.osc_enable == !$past(wb[cal_ctrl_pkg::SRC_BIT]);
  endproperty
  a_osc: assert property (p_osc)
    else $error("oscillator enable wrong");

  property p_src_follows;
    @(posedge i_sys_clk) disable iff (i_reset)
    ctrl_wr |=> o_cfg.mains_source == $past(wb[cal_ctrl_pkg::SRC_BIT]);
  endproperty
  a_src_follows: assert property (p_src_follows)
    else $error("tick source select not written");

  property p_div;
    @(posedge i_sys_clk) disable iff (i_reset)
    mains_src |-> divisor == (rate_sel ? cal_ctrl_pkg::DIV_50HZ : cal_ctrl_pkg::DIV_60HZ);
  endproperty
  a_div: assert property (p_div)
    else $error("mains divisor wrong");

  property p_write_restarts;
    @(posedge i_sys_clk) disable iff (i_reset)
    ctrl_wr |=> !o_second ##1 !o_second;
  endproperty
  a_write_restarts: assert property (p_write_restarts)
    else $error("prescaler not restarted");

  property p_bcd_follows;
    @(posedge i_sys_clk) disable iff (i_reset)
    ctrl_wr |=> o_cfg.bcd_mode == $past(wb[cal_ctrl_pkg::BCD_BIT]);
  endproperty
  a_bcd_follows: assert property (p_bcd_follows)
    else $error("bcd select not written");

  // leaving system reset: enable and unlock come back cleared
  property p_reset_clears;
    @(posedge i_sys_clk) disable iff (i_por)
    $fell(i_reset) |-> !int_en && !unlock;
  endproperty
  a_reset_clears: assert property (p_reset_clears)
    else $error("enable or unlock not cleared by reset");

  // system reset alone must not disturb the configuration bits
  property p_cfg_keep;
    @(posedge i_sys_clk) disable iff (i_por)
    i_reset && !ctrl_wr |=> bcd_mode == $past(bcd_mode) && mains_src == $past(mains_src)
                            && rate_sel == $past(rate_sel);
  endproperty
  a_cfg_keep: assert property (p_cfg_keep)
    else $error("configuration changed by system reset");

  c_read_clear: cover property (@(posedge i_sys_clk) alarm ##1 ctrl_rd ##1 !alarm);
  c_lock: cover property (@(posedge i_sys_clk) lock_evt);
  c_wake: cover property (@(posedge i_sys_clk) o_wake_req);
  c_second: cover property (@(posedge i_sys_clk) o_second && mains_src);
  c_reset_keep: cover property (@(posedge i_sys_clk) $fell(i_reset) && bcd_mode);
endmodule
`default_nettype wire

/* File: verilog/cal_ctrl_pkg.sv */
// package: register map, field layout and timing constants for the calendar control block
`default_nettype none
package cal_ctrl_pkg;
  // register byte addresses (printed offsets are not all multiples of four: index times four)
  localparam logic [7:0]  CTRL_INDEX     = 8'hED;
  localparam logic [11:0] CTRL_ADDR      = 12'h3B4;
  localparam logic [11:0] IRQ_STAT_ADDR  = 12'h400;
  localparam logic [11:0] IRQ_MASK_ADDR  = 12'h404;
  localparam logic [11:0] MATCH_ADDR     = 12'h408;
  // control field positions
  localparam int ALARM_BIT  = 7;
  localparam int INTEN_BIT  = 6;
  localparam int BCD_BIT    = 5;
  localparam int SRC_BIT    = 4;
  localparam int RATE_BIT   = 3;
  localparam int WAKE_BIT   = 1;
  localparam int UNLOCK_BIT = 0;
  // configuration bits are unchanged by reset; these are the power-on values
  localparam logic [7:0] CTRL_POWERON = 8'h00;
  // interrupt status layout
  localparam int EV_ALARM = 0;
  localparam int EV_TICK  = 1;
  localparam int EV_WAKE  = 2;
  localparam int EV_N     = 3;
  // prescale divisors
  localparam logic [15:0] DIV_XTAL  = 16'h8000;
  localparam logic [15:0] DIV_60HZ  = 16'h003C;
  localparam logic [15:0] DIV_50HZ  = 16'h0032;
  // bundle of configuration outputs
  typedef struct packed {
    logic bcd_mode;
    logic mains_source;
    logic osc_enable;
    logic unlock;
  } cal_cfg_t;
endpackage
`default_nettype wire

/* File: verilog/cal_prescaler.sv */
// tick prescaler: divides the selected tick source down to one pulse per second
`timescale 1ns/10ps
`default_nettype none
module cal_prescaler (
  input  wire logic        i_sys_clk,  // system clock
  input  wire logic        i_reset,    // async reset, high
  input  wire logic        i_clear,    // restart the count
  input  wire logic        i_step,     // one source edge
  input  wire logic [15:0] i_divisor,  // edges per second
  output logic             o_second    // one-cycle second tick
);
  logic [15:0] count;
  // count source edges; wrap and pulse at the divisor
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      count    <= 16'h0000;
      o_second <= 1'b0;
    end else begin
      o_second <= 1'b0;
      if (i_clear) begin
        count <= 16'h0000;
      end else if (i_step) begin
        if (count >= i_divisor - 16'h0001) begin
          count    <= 16'h0000;
          o_second <= 1'b1;
        end else begin
          count <= count + 16'h0001;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: verilog/cal_sync.sv */
// two-flop synchroniser with rising-edge pulse taken after the second stage
`timescale 1ns/10ps
`default_nettype none
module cal_sync (
  input  wire logic i_sys_clk,   // system clock
  input  wire logic i_reset,     // async reset, high
  input  wire logic i_async,     // level from outside the domain
  output logic      o_level,     // synchronised level
  output logic      o_rise       // one-cycle pulse on rising edge
);
  logic meta;
  logic last;
  // first stage feeds only the second
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      meta    <= 1'b0;
      o_level <= 1'b0;
      last    <= 1'b0;
    end else begin
      meta    <= i_async;
      o_level <= meta;
      last    <= o_level;
    end
  end
  assign o_rise = o_level & ~last;
endmodule
`default_nettype wire
